// ===== hw/sram_cycle_map.svh
// constants of the pipelined sram cycle control
`ifndef SRAM_CYCLE_MAP_SVH
`define SRAM_CYCLE_MAP_SVH
`define ADDR_W 17
`define LANES 4
`define LANE_W 8
`define WORD_W 32
`define BURST_LEN 4
`define NO_LANES 4'hF
`define MEM_DEPTH 1024
`endif

// ===== hw/sram_cycle_pkg.sv
// types of the pipelined sram cycle control
`include "sram_cycle_map.svh"
package sram_cycle_pkg;
  typedef enum logic [1:0] {
    OP_IDLE = 2'b00,
    OP_READ = 2'b01,
    OP_WRITE = 2'b10
  } op_t;
  typedef struct packed {
    logic [`WORD_W-1:0] data;
    logic [`LANES-1:0] parity;
  } word_t;
  typedef struct packed {
    op_t op;
    logic [`ADDR_W-1:0] addr;
    logic [`LANES-1:0] lane_n;
  } stage_t;
endpackage

// ===== hw/burst_counter.sv
// two-bit burst address sequencer
`timescale 1ns/1ps
module burst_counter
  import sram_cycle_pkg::*;
(
  input wire logic [1:0] start,
  input wire logic [1:0] step,
  input wire logic interleave,
  output logic [1:0] low_bits
);
  logic [1:0] linear;
  assign linear = 2'(start + step);
  assign low_bits = interleave ? (start ^ step) : linear;
endmodule

// ===== hw/sram_cycle_control.sv
// cycle decode, byte write and data pins of the pipelined burst sram
//
// How it works
// - deselect edge floats data and parity after the next recognized edge.
// - clock hold high freezes every internal state except the input synchronisers.
// - begin write latches address; data is taken two recognized edges later.
// - advance with a read in progress continues the read burst.
// - advance with a write in progress writes lanes chosen that cycle.
// - each continuation advances the internal address by the mode order.
// - after reset the device is deselected with pins floating.
// - pins driven only for read data and only while output enable is low.
// - write strobe high means read; all lane selects high writes nothing.
// - each lane select writes one byte and its parity bit.
// - unselected lanes keep their memory contents.
// - pins float during the data part of any write.
// - begin read latches address; data appears after the following edge.
// - mode low linear, high interleaved, wrapping over two low address bits.
`timescale 1ns/1ps
`include "sram_cycle_map.svh"
module sram_cycle_control
  import sram_cycle_pkg::*;
#(
  parameter int DEPTH = `MEM_DEPTH
)(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic chip_sel1_n,
  input wire logic chip_sel2,
  input wire logic chip_sel3_n,
  input wire logic clock_hold_n,
  input wire logic advance_load,
  input wire logic write_n,
  input wire logic [`LANES-1:0] byte_lane_select_n,
  input wire logic burst_mode,
  input wire logic out_enable_n,
  input wire logic [`ADDR_W-1:0] addr,
  input wire logic [`WORD_W-1:0] dq_in,
  input wire logic [`LANES-1:0] parity_lines_in,
  output logic [`WORD_W-1:0] dq_out,
  output logic [`LANES-1:0] parity_lines_out,
  output logic [`WORD_W-1:0] dq_oe_n,
  output logic [`LANES-1:0] parity_lines_oe_n
);
  if (DEPTH < 4 || DEPTH > (1 << `ADDR_W) || (DEPTH & (DEPTH - 1)) != 0) begin : depth_check
    $error("DEPTH must be a power of two from 4 to the address space");
  end
  localparam int IDX_W = $clog2(DEPTH);

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [`ADDR_W+`LANES+7+`WORD_W+`LANES-1:0] pins_a_q, pins_b_q;
  always_ff @(posedge core_clk) begin
    pins_a_q <= {chip_sel1_n, chip_sel2, chip_sel3_n, clock_hold_n, advance_load, write_n,
                 burst_mode, byte_lane_select_n, addr, dq_in, parity_lines_in};
    pins_b_q <= pins_a_q;
  end
  logic s_cs1_n, s_cs2, s_cs3_n, s_hold_n, s_adv, s_we_n, s_mode;
  logic [`LANES-1:0] s_lane_n, s_par;
  logic [`ADDR_W-1:0] s_addr;
  logic [`WORD_W-1:0] s_dq;
  assign {s_cs1_n, s_cs2, s_cs3_n, s_hold_n, s_adv, s_we_n, s_mode, s_lane_n, s_addr, s_dq, s_par} = pins_b_q;
  logic oe_a_q, oe_b_q;
  always_ff @(posedge core_clk) begin
    oe_a_q <= out_enable_n;
    oe_b_q <= oe_a_q;
  end

  // ----------------------------------------
  // cycle decode
  // ----------------------------------------
  logic run, selected, load, begin_rd, begin_wr, desel, cont;
  assign run = !s_hold_n;
  assign selected = !s_cs1_n && s_cs2 && !s_cs3_n;
  assign load = run && !s_adv;
  assign begin_rd = load && selected && s_we_n;
  assign begin_wr = load && selected && !s_we_n;
  assign desel = load && !selected;
  assign cont = run && s_adv;

  // ----------------------------------------
  // burst tracking and address stage
  // ----------------------------------------
  op_t burst_op_q, burst_op_d;
  logic [`ADDR_W-1:0] base_q, base_d;
  logic [1:0] step_q, step_d;
  logic mode_q, mode_d;
  logic [1:0] low_bits;
  burst_counter u_burst (
    .start(base_q[1:0]),
    .step(2'(step_q + 2'h1)),
    .interleave(mode_q),
    .low_bits(low_bits)
  );
  stage_t addr_stage, data_stage_q, data_stage_d, wr_stage_q, wr_stage_d;
  always_comb begin
    burst_op_d = burst_op_q;
    base_d = base_q;
    step_d = step_q;
    mode_d = mode_q;
    addr_stage = '{op: OP_IDLE, addr: '0, lane_n: `NO_LANES};
    if (begin_rd || begin_wr) begin
      burst_op_d = begin_rd ? OP_READ : OP_WRITE;
      base_d = s_addr;
      step_d = 2'h0;
      mode_d = s_mode;
      addr_stage = '{op: burst_op_d, addr: s_addr, lane_n: s_lane_n};
    end else if (desel) begin
      burst_op_d = OP_IDLE;
    end else if (cont && burst_op_q != OP_IDLE) begin
      step_d = 2'(step_q + 2'h1);
      addr_stage = '{op: burst_op_q, addr: {base_q[`ADDR_W-1:2], low_bits}, lane_n: s_lane_n};
    end
  end

  // ----------------------------------------
  // pipeline stages
  // ----------------------------------------
  assign data_stage_d = run ? addr_stage : data_stage_q;
  assign wr_stage_d = run ? data_stage_q : wr_stage_q;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      burst_op_q <= OP_IDLE;
      base_q <= '0;
      step_q <= 2'h0;
      mode_q <= 1'b0;
      data_stage_q <= '{op: OP_IDLE, addr: '0, lane_n: `NO_LANES};
      wr_stage_q <= '{op: OP_IDLE, addr: '0, lane_n: `NO_LANES};
    end else begin
      burst_op_q <= run ? burst_op_d : burst_op_q;
      base_q <= run ? base_d : base_q;
      step_q <= run ? step_d : step_q;
      mode_q <= run ? mode_d : mode_q;
      data_stage_q <= data_stage_d;
      wr_stage_q <= wr_stage_d;
    end
  end

  // ----------------------------------------
  // memory array with lane writes
  // ----------------------------------------
  word_t mem [DEPTH];
  logic do_write;
  logic [IDX_W-1:0] wr_idx, rd_idx;
  assign wr_idx = wr_stage_q.addr[IDX_W-1:0];
  assign rd_idx = data_stage_q.addr[IDX_W-1:0];
  assign do_write = run && wr_stage_q.op == OP_WRITE;
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < `LANES; i++) begin
      if (do_write && !wr_stage_q.lane_n[i]) begin
        mem[wr_idx].data[i*`LANE_W +: `LANE_W] <= s_dq[i*`LANE_W +: `LANE_W];
        mem[wr_idx].parity[i] <= s_par[i];
      end
    end
  end

  // ----------------------------------------
  // output register and enables
  // ----------------------------------------
  logic [`WORD_W-1:0] dq_q;
  logic [`LANES-1:0] par_q;
  logic rd_valid_q;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      dq_q <= '0;
      par_q <= '0;
      rd_valid_q <= 1'b0;
    end else if (run) begin
      rd_valid_q <= data_stage_q.op == OP_READ;
      if (data_stage_q.op == OP_READ) begin
        dq_q <= mem[rd_idx].data;
        par_q <= mem[rd_idx].parity;
      end
    end
  end
  logic drive;
  assign drive = rd_valid_q && !oe_b_q;
  assign dq_out = dq_q;
  assign parity_lines_out = par_q;
  assign dq_oe_n = {`WORD_W{!drive}};
  assign parity_lines_oe_n = {`LANES{!drive}};

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_desel_float;
    @(posedge core_clk) disable iff (rst) (desel ##1 run) |=> dq_oe_n == '1 && parity_lines_oe_n == '1;
  endproperty
  a_desel_float: assert property (p_desel_float) else $error("deselect did not float pins");
  property p_hold_freeze;
    @(posedge core_clk) disable iff (rst) !run |=> $stable(data_stage_q) && $stable(step_q);
  endproperty
  a_hold_freeze: assert property (p_hold_freeze) else $error("state moved under clock hold");
  property p_write_lands;
    @(posedge core_clk) disable iff (rst) (begin_wr ##1 run ##1 run) |-> do_write;
  endproperty
  a_write_lands: assert property (p_write_lands) else $error("write data not taken two edges later");
  property p_read_cont;
    @(posedge core_clk) disable iff (rst) (cont && burst_op_q == OP_READ) |=> data_stage_q.op == OP_READ;
  endproperty
  a_read_cont: assert property (p_read_cont) else $error("read burst not continued");
  property p_write_cont;
    @(posedge core_clk) disable iff (rst)
      (cont && burst_op_q == OP_WRITE) |=> data_stage_q.lane_n == $past(s_lane_n);
  endproperty
  a_write_cont: assert property (p_write_cont) else $error("burst write lanes wrong");
  property p_step;
    @(posedge core_clk) disable iff (rst)
      (cont && burst_op_q != OP_IDLE && !begin_rd) |=> step_q == $past(step_q) + 2'h1;
  endproperty
  a_step: assert property (p_step) else $error("burst counter did not advance");
  property p_oe_gate;
    @(posedge core_clk) disable iff (rst)
      !dq_oe_n[0] |-> !oe_b_q && ($past(data_stage_q.op) == OP_READ || !$past(run))
        && dq_oe_n == '0 && parity_lines_oe_n == '0;
  endproperty
  a_oe_gate: assert property (p_oe_gate) else $error("pins driven without read or enable");
  property p_write_float;
    @(posedge core_clk) disable iff (rst) (data_stage_q.op == OP_WRITE && run) |=> dq_oe_n == {`WORD_W{1'b1}};
  endproperty
  a_write_float: assert property (p_write_float) else $error("pins driven during write data");
  property p_read_data;
    @(posedge core_clk) disable iff (rst) (begin_rd ##1 run ##1 run) |-> rd_valid_q;
  endproperty
  a_read_data: assert property (p_read_data) else $error("read data not delivered");
endmodule

// ===== bench/ctrl_model.sv
// controller model that drives the sram pins
`timescale 1ns/1ps
module ctrl_model
  import sram_cycle_pkg::*;
(
  input wire logic core_clk,
  output logic chip_sel1_n,
  output logic chip_sel2,
  output logic chip_sel3_n,
  output logic clock_hold_n,
  output logic advance_load,
  output logic write_n,
  output logic [3:0] byte_lane_select_n,
  output logic burst_mode,
  output logic out_enable_n,
  output logic [16:0] addr,
  output logic [31:0] dq_in,
  output logic [3:0] parity_lines_in
);
  logic [36:0] w0 = '0, w1 = '0;
  logic [35:0] pat = '1;
  logic wt = 0;
  assign {dq_in, parity_lines_in} = pat;
  initial begin
    {chip_sel1_n, chip_sel2, chip_sel3_n, clock_hold_n, advance_load, write_n} = 6'h29;
    {byte_lane_select_n, burst_mode, out_enable_n, addr} = '1;
  end
  // write data two edges after its command, else a changing pattern
  always @(posedge core_clk) begin
    w1 <= w0;
    pat <= w1[36] ? w1[35:0] : ~pat;
  end
  // one cycle of pins; a new access has all selects active
  task automatic op(input logic s, hold, adv, wn, input logic [3:0] ln, input logic [16:0] a,
    input logic bm, input logic [35:0] d);
    @(posedge core_clk);
    {chip_sel1_n, chip_sel2, chip_sel3_n} <= s ? 3'h2 : 3'h5;
    {clock_hold_n, advance_load, write_n, byte_lane_select_n, addr, burst_mode} <= {hold, adv, wn, ln, a, bm};
    if (!adv && !hold) wt = s && !wn;
    w0 <= {wt && !hold, d};
  endtask
  task automatic oe(input logic v);
    @(posedge core_clk);
    out_enable_n <= v;
  endtask
endmodule

// ===== bench/tb.sv
// self-checking bench of the sram cycle control
`timescale 1ns/1ps
module tb;
  logic core_clk, rst, chip_sel1_n, chip_sel2, chip_sel3_n, clock_hold_n, advance_load, write_n;
  logic burst_mode, out_enable_n;
  logic [3:0] byte_lane_select_n, parity_lines_in, parity_lines_out, parity_lines_oe_n;
  logic [16:0] addr;
  logic [31:0] dq_in, dq_out, dq_oe_n;
  logic [35:0] mem [16];
  logic [35:0] q [$];
  int miscompares = 0;
  int checks_done = 0;
  sram_cycle_control #(.DEPTH(16)) sram_cycle_control_i (
    .core_clk(core_clk), .rst(rst), .chip_sel1_n(chip_sel1_n), .chip_sel2(chip_sel2), .chip_sel3_n(chip_sel3_n),
    .clock_hold_n(clock_hold_n), .advance_load(advance_load), .write_n(write_n),
    .byte_lane_select_n(byte_lane_select_n), .burst_mode(burst_mode), .out_enable_n(out_enable_n), .addr(addr),
    .dq_in(dq_in), .parity_lines_in(parity_lines_in), .dq_out(dq_out), .parity_lines_out(parity_lines_out),
    .dq_oe_n(dq_oe_n), .parity_lines_oe_n(parity_lines_oe_n)
  );
  ctrl_model ctrl_model_i (
    .core_clk(core_clk), .chip_sel1_n(chip_sel1_n), .chip_sel2(chip_sel2), .chip_sel3_n(chip_sel3_n),
    .clock_hold_n(clock_hold_n), .advance_load(advance_load), .write_n(write_n),
    .byte_lane_select_n(byte_lane_select_n), .burst_mode(burst_mode), .out_enable_n(out_enable_n), .addr(addr),
    .dq_in(dq_in), .parity_lines_in(parity_lines_in)
  );
  task automatic chk(input string n, input logic [35:0] e, s);
    checks_done++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  function automatic logic [3:0] ba(input logic [16:0] a, input int i, input logic bm);
    return {a[3:2], bm ? a[1:0] ^ 2'(i) : a[1:0] + 2'(i)};
  endfunction
  task automatic idle(input int n);
    repeat (n) ctrl_model_i.op(0, 0, 0, 1, 4'hF, '0, 0, '0);
  endtask
  task automatic wr(input logic [16:0] a, input int n, input logic bm, input logic [3:0] ln, input logic [35:0] d);
    logic [35:0] e;
    for (int i = 0; i < n + 6; i++) begin
      e = d + 36'(i);
      if (i < n) begin
        ctrl_model_i.op(1, 0, i > 0, i > 0, ln, a, bm, e);
        for (int j = 0; j < 36; j++) if (!ln[j < 4 ? j : (j - 4) / 8]) mem[ba(a, i, bm)][j] = e[j];
        ln = {ln[2:0], ln[3]};
      end else idle(1);
      #1 chk("oe in write", '1, {dq_oe_n, parity_lines_oe_n});
    end
  endtask
  task automatic rd(input logic [16:0] a, input int n, input logic bm, en_n);
    q.delete();
    ctrl_model_i.oe(en_n);
    idle(3);
    for (int i = 0; i < n + 8; i++) begin
      if (i < n) ctrl_model_i.op(i == 0, 0, i > 0, i == 0, 4'h0, a, bm, '0);
      else idle(1);
      #1 if (dq_oe_n === '0) q.push_back({dq_out, parity_lines_out});
    end
    chk("read count", en_n ? 0 : n, q.size());
    foreach (q[i]) chk("read data", mem[ba(a, i, bm)], q[i]);
    chk("oe deselect", '1, {dq_oe_n, parity_lines_oe_n});
  endtask
  task automatic t_single();
    wr(17'h3, 1, 0, 4'h0, 36'h1_2345_6789);
    rd(17'h3, 1, 0, 1);
    rd(17'h3, 1, 0, 0);
    wr(17'h3, 1, 0, 4'hA, 36'hA_BCDE_F012);
    wr(17'h3, 1, 0, 4'hF, 36'h5_5555_5555);
    rd(17'h3, 1, 0, 0);
    $display("test single done");
  endtask
  task automatic t_burst();
    for (int b = 0; b < 16; b += 4) wr(17'(b), 4, 0, 4'h0, 36'h9_0000_0001 + 36'(b));
    wr(17'h5, 4, 0, 4'h1, 36'h3_0303_0303);
    rd(17'h6, 4, 1, 0);
    rd(17'hA, 4, 0, 0);
    $display("test burst done");
  endtask
  task automatic t_hold();
    int n = 0;
    repeat (12) ctrl_model_i.op(1, 1, 0, 0, 4'h0, 17'h3, 0, 36'h0_DEAD_BEEF);
    rd(17'h3, 1, 0, 0);
    // read data caught by clock hold stands until the next recognized edge
    for (int i = 0; i < 12; i++) begin
      ctrl_model_i.op(i == 0, i >= 2 && i < 5, 0, 1, 4'h0, 17'h3, 0, '0);
      #1 if (dq_oe_n === '0) begin
        n++;
        chk("held read data", mem[3], {dq_out, parity_lines_out});
      end
    end
    chk("held read count", 4, n);
    $display("test hold done");
  endtask
  task automatic t_reset();
    ctrl_model_i.oe(0);
    ctrl_model_i.op(1, 0, 0, 1, 4'h0, 17'h3, 0, '0);
    idle(1);
    rst <= 1;
    idle(16);
    rst <= 0;
    for (int i = 0; i < 4; i++) begin
      idle(1);
      #1 chk("oe after reset", '1, {dq_oe_n, parity_lines_oe_n});
    end
    rd(17'h3, 1, 0, 0);
    $display("test reset done");
  endtask
  initial begin
    core_clk = 0;
    forever #20 core_clk = ~core_clk;
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    print_verdict();
  end
  initial begin
    rst = 1;
    repeat (16) @(posedge core_clk);
    rst <= 0;
    #1 chk("oe reset", '1, {dq_oe_n, parity_lines_oe_n});
    t_single();
    t_burst();
    t_hold();
    t_reset();
    print_verdict();
  end
endmodule
